// >>> bench/esirq_chk.sv
// Port checker of the external interrupt sense block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module esirq_chk
    import esirq_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rstn,
    // Register port.
    input wire esirq_bus_req_type bus_req,
    input wire logic [7:0] rd_data,
    // Pins and processor side.
    input wire logic [7:0] ext_request_input,
    input wire logic [7:0] exc_ack,
    input wire logic [7:0] irq_request,
    input wire logic irq_out
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    a_rd_idle_zero: assert property (!$past(bus_req.rd) |-> rd_data == 8'h00)
        else $error("read data outside a read answer");
    a_rd_unmapped_zero: assert property (bus_req.rd && (bus_req.addr < OFS_SENSE_CTRL_HIGH
        || bus_req.addr > OFS_EVENT_MASK) |=> rd_data == UNMAPPED_READ)
        else $error("unmapped read not zero");
    a_sense_readback: assert property (bus_req.wr && bus_req.addr == OFS_SENSE_CTRL_HIGH
        ##1 !bus_req.wr ##1 bus_req.rd && bus_req.addr == OFS_SENSE_CTRL_HIGH
        |=> rd_data == $past(bus_req.wdata, 3)) else $error("sense high readback");
    // A flag can only appear from a pin that moved or sits low, or from a register write.
    a_req_rise_cause: assert property (|(irq_request & ~$past(irq_request)) |->
        $past(bus_req.wr) || $past(ext_request_input) != $past(ext_request_input, 2)
        || !(&$past(ext_request_input))) else $error("request rose without cause");
    a_req_fall_cause: assert property (|(~irq_request & $past(irq_request)) |->
        $past(bus_req.wr) || $past(exc_ack) != 8'h00) else $error("request fell without cause");
    a_out_rise_cause: assert property ($rose(irq_out) |-> $past(bus_req.wr)
        || $past(ext_request_input) != $past(ext_request_input, 2)
        || !(&$past(ext_request_input))) else $error("interrupt rose without cause");
    a_out_fall_write: assert property ($fell(irq_out) |-> $past(bus_req.wr))
        else $error("interrupt fell without a write");
    a_quiet_hold: assert property (!$past(bus_req.wr) && $past(exc_ack) == 8'h00
        && $past(ext_request_input) == $past(ext_request_input, 2) && &$past(ext_request_input)
        |-> $stable(irq_request) && $stable(irq_out)) else $error("outputs moved while quiet");
    c_irq_rise: cover property ($rose(irq_out));
    c_ack_pending: cover property (|(exc_ack & irq_request));
    c_status_clear: cover property (bus_req.rd && bus_req.addr == OFS_STATUS_FLAGS
        ##2 bus_req.wr && bus_req.addr == OFS_STATUS_FLAGS);
endmodule // esirq_chk
bind esirq_top esirq_chk esirq_chk_inst (.mclk(mclk), .rstn(rstn), .bus_req(bus_req),
    .rd_data(rd_data), .ext_request_input(ext_request_input), .exc_ack(exc_ack),
    .irq_request(irq_request), .irq_out(irq_out));
`default_nettype wire

// >>> bench/esirq_pin_model.sv
// Behavioural source of the eight external request pins.
`timescale 1ns/1ps
`default_nettype none
module esirq_pin_model (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rstn,
    // Level wanted by the bench.
    input wire logic [7:0] level_cmd,
    // Pins towards the block.
    output logic [7:0] ext_request_input
);
    // Pins rest high as pull-ups hold them; a move lands one cycle after its command.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ext_request_input <= 8'hff;
        end else begin
            ext_request_input <= level_cmd;
        end
    end
endmodule // esirq_pin_model
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench of the external interrupt sense block.
`timescale 1ns/1ps
`default_nettype none
module tb
    import esirq_pkg::*;
;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    esirq_bus_req_type bus_req = '0;
    logic [7:0] level_cmd = 8'hff;
    logic [7:0] exc_ack = 8'h00;
    logic [7:0] pins;
    logic [7:0] rd_data;
    logic [7:0] irq_request;
    logic irq_out;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #10 mclk = ~mclk;

    esirq_pin_model esirq_pin_model_inst (.mclk(mclk), .rstn(rstn), .level_cmd(level_cmd),
        .ext_request_input(pins));
    esirq_top esirq_top_inst (.mclk(mclk), .rstn(rstn), .bus_req(bus_req), .rd_data(rd_data),
        .ext_request_input(pins), .exc_ack(exc_ack), .irq_request(irq_request),
        .irq_out(irq_out));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req <= '0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req <= '0;
        #1 check(rd_data, exp, "read data");
        @(posedge mclk);
    endtask

    task automatic outs(input logic [7:0] req, input logic irq);
        #1 check(irq_request, req, "requests");
        check({7'h00, irq_out}, {7'h00, irq}, "interrupt");
        @(posedge mclk);
    endtask

    // The model needs one edge to move the pins and the block one more to see them.
    task automatic pin(input logic [7:0] v);
        level_cmd <= v;
        repeat (3) @(posedge mclk);
    endtask

    task automatic ack(input logic [7:0] m);
        exc_ack <= m;
        @(posedge mclk);
        exc_ack <= 8'h00;
        @(posedge mclk);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            finish_test;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rd(OFS_SENSE_CTRL_HIGH, 8'h00);
        rd(OFS_SENSE_CTRL_LOW, 8'h00);
        rd(OFS_LINE_ENABLES, 8'h00);
        rd(OFS_STATUS_FLAGS, 8'h00);
        rd(16'hfe18, UNMAPPED_READ);
        $display("test reset done");
        // Each group of four channels holds all four modes, mode 00 at the bottom.
        wr(OFS_SENSE_CTRL_HIGH, 8'he4);
        rd(OFS_SENSE_CTRL_HIGH, 8'he4);
        wr(OFS_SENSE_CTRL_LOW, 8'he4);
        wr(OFS_LINE_ENABLES, 8'hff);
        wr(OFS_EVENT_MASK, 8'hff);
        pin(8'h00);
        outs(8'hbb, 1'b1);
        rd(OFS_STATUS_FLAGS, 8'hbb);
        pin(8'hff);
        rd(OFS_STATUS_FLAGS, 8'hff);
        wr(OFS_STATUS_FLAGS, 8'h00);
        rd(OFS_STATUS_FLAGS, 8'h00);
        outs(8'h00, 1'b1);
        wr(OFS_EVENT_STATUS, 8'hff);
        outs(8'h00, 1'b0);
        $display("test sense modes done");
        // Clearing without a prior read, and writing ones, must both leave the flag set.
        pin(8'hfd);
        wr(OFS_STATUS_FLAGS, 8'h00);
        rd(OFS_STATUS_FLAGS, 8'h02);
        wr(OFS_STATUS_FLAGS, 8'hff);
        rd(OFS_STATUS_FLAGS, 8'h02);
        wr(OFS_STATUS_FLAGS, 8'h00);
        rd(OFS_STATUS_FLAGS, 8'h00);
        $display("test clear protocol done");
        wr(OFS_LINE_ENABLES, 8'h00);
        pin(8'hff);
        pin(8'hfd);
        outs(8'h00, 1'b1);
        wr(OFS_LINE_ENABLES, 8'h02);
        outs(8'h02, 1'b1);
        ack(8'h02);
        outs(8'h00, 1'b1);
        wr(OFS_LINE_ENABLES, 8'h01);
        pin(8'hfc);
        ack(8'h01);
        outs(8'h01, 1'b1);
        pin(8'hff);
        ack(8'h01);
        outs(8'h00, 1'b1);
        wr(OFS_EVENT_MASK, 8'h00);
        outs(8'h00, 1'b0);
        wr(OFS_EVENT_MASK, 8'hff);
        outs(8'h00, 1'b1);
        wr(OFS_EVENT_STATUS, 8'hff);
        outs(8'h00, 1'b0);
        $display("test enables and handling done");
        finish_test;
    end
endmodule // tb
`default_nettype wire

// >>> rtl/esirq_pkg.sv
// Constants, register map and carrier types of the external interrupt sense block.
package esirq_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths.
    localparam int ESIRQ_ADDR_W = 16;
    localparam int ESIRQ_DATA_W = 8;
    localparam int ESIRQ_NUM_CH = 8;
    localparam int ESIRQ_CH_PER_REG = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets on the byte-wide register port.
    localparam logic [15:0] OFS_SENSE_CTRL_HIGH = 16'hfe12;
    localparam logic [15:0] OFS_SENSE_CTRL_LOW = 16'hfe13;
    localparam logic [15:0] OFS_LINE_ENABLES = 16'hfe14;
    localparam logic [15:0] OFS_STATUS_FLAGS = 16'hfe15;
    localparam logic [15:0] OFS_EVENT_STATUS = 16'hfe16;
    localparam logic [15:0] OFS_EVENT_MASK = 16'hfe17;

    ////////////////////////////////////////////////////////////////////////////////
    // Values after reset.
    localparam logic [7:0] RST_SENSE_CTRL_HIGH = 8'h00;
    localparam logic [7:0] RST_SENSE_CTRL_LOW = 8'h00;
    localparam logic [7:0] RST_LINE_ENABLES = 8'h00;
    localparam logic [7:0] RST_STATUS_FLAGS = 8'h00;
    localparam logic [7:0] RST_ARMED = 8'h00;
    localparam logic [7:0] RST_EVENT_STATUS = 8'h00;
    localparam logic [7:0] RST_EVENT_MASK = 8'h00;
    localparam logic [7:0] RST_PREV_INPUT = 8'hff;
    localparam logic [7:0] RST_READ_DATA = 8'h00;
    localparam logic [7:0] RST_REQUESTS = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Sense selection: upper bit above lower bit.
    typedef enum logic [1:0] {
        SENSE_LOW_LEVEL = 2'h0,
        SENSE_FALLING = 2'h1,
        SENSE_RISING = 2'h2,
        SENSE_BOTH_EDGES = 2'h3
    } esirq_sense_type;

    ////////////////////////////////////////////////////////////////////////////////
    // Register port request.
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } esirq_bus_req_type;

    // Whole state of the top module.
    typedef struct packed {
        logic [7:0] sense_ctrl_high;
        logic [7:0] sense_ctrl_low;
        logic [7:0] enable_register;
        logic [7:0] channel_pending_flag;
        logic [7:0] armed;
        logic [7:0] prev_input;
        logic [7:0] event_status;
        logic [7:0] event_mask;
        logic [7:0] read_data;
        logic [7:0] requests;
        logic irq;
    } esirq_state_type;

endpackage : esirq_pkg

// >>> rtl/esirq_top.sv
// Eight-channel external interrupt sense, flag and enable logic with its register port.
//
// How it works
// [R1] With both select bits of a channel at 0, its flag is set in every cycle the input is low.
// [R2] With select 0,1 the flag is set on each falling edge of that channel's input.
// [R3] With select 1,0 the flag is set on each rising edge of that channel's input.
// [R4] With select 1,1 the flag is set on every falling and every rising edge of the input.
// [R5] Each channel has an enable bit, reset to 0; only an enabled channel reaches irq_request, while irq_out ignores the enables.
// [R6] The high sense register keeps the select pairs of channels 7 to 4, reset to 0.
// [R7] The low sense register keeps the select pairs of channels 3 to 0, reset to 0.
// [R8] A channel's flag is set whenever its input meets the chosen sense condition.
// [R9] Software clears a flag by reading it as 1 and then writing 0; writing 1 does nothing. Here a write of 1 also disarms the flag until the next read.
// [R10] Exception handling clears a flag in edge modes, or in level mode while the input is high.
// [R11] The request sent to the CPU for a channel is its flag ANDed with its enable bit.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module esirq_top
    import esirq_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rstn,

    // Register port.
    input wire esirq_bus_req_type bus_req,
    output logic [7:0] rd_data,

    // External request pins.
    input wire logic [7:0] ext_request_input,

    // Processor side.
    input wire logic [7:0] exc_ack,
    output logic [7:0] irq_request,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    esirq_state_type state_q;
    esirq_state_type state_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Access decode.

    logic wr_sense_high;
    logic wr_sense_low;
    logic wr_enables;
    logic wr_status;
    logic rd_status;
    logic wr_event_status;
    logic wr_event_mask;

    assign wr_sense_high = bus_req.wr && (bus_req.addr == OFS_SENSE_CTRL_HIGH);
    assign wr_sense_low = bus_req.wr && (bus_req.addr == OFS_SENSE_CTRL_LOW);
    assign wr_enables = bus_req.wr && (bus_req.addr == OFS_LINE_ENABLES);
    assign wr_status = bus_req.wr && (bus_req.addr == OFS_STATUS_FLAGS);
    assign rd_status = bus_req.rd && (bus_req.addr == OFS_STATUS_FLAGS);
    assign wr_event_status = bus_req.wr && (bus_req.addr == OFS_EVENT_STATUS);
    assign wr_event_mask = bus_req.wr && (bus_req.addr == OFS_EVENT_MASK);

    ////////////////////////////////////////////////////////////////////////////////
    // Select pair of one channel, upper bit first.

    function automatic esirq_sense_type sense_of(
        input logic [7:0] high_reg,
        input logic [7:0] low_reg,
        input int ch
    );
        logic [1:0] pair;
        int pos;
        pair = 2'h0;
        pos = 0;
        if (ch < ESIRQ_CH_PER_REG) begin
            pos = 2 * ch;
            pair = low_reg[pos +: 2]; // see [R7]
        end else begin
            pos = 2 * (ch - ESIRQ_CH_PER_REG);
            pair = high_reg[pos +: 2]; // see [R6]
        end
        sense_of = esirq_sense_type'(pair);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel detection and flag upkeep.

    logic [7:0] detect;
    logic [7:0] clear_sw;
    logic [7:0] clear_hw;
    logic [7:0] new_event;

    always_comb begin
        esirq_sense_type mode;
        logic fell;
        logic rose;
        mode = SENSE_LOW_LEVEL;
        fell = 1'b0;
        rose = 1'b0;
        detect = 8'h00;
        clear_sw = 8'h00;
        clear_hw = 8'h00;
        for (int i = 0; i < ESIRQ_NUM_CH; i++) begin
            mode = sense_of(state_q.sense_ctrl_high, state_q.sense_ctrl_low, i);
            fell = state_q.prev_input[i] && !ext_request_input[i];
            rose = !state_q.prev_input[i] && ext_request_input[i];
            case (mode)
                SENSE_LOW_LEVEL: begin
                    detect[i] = !ext_request_input[i]; // see [R1] see [R8]
                end
                SENSE_FALLING: begin
                    detect[i] = fell; // see [R2] see [R8]
                end
                SENSE_RISING: begin
                    detect[i] = rose; // see [R3] see [R8]
                end
                SENSE_BOTH_EDGES: begin
                    detect[i] = fell || rose; // see [R4] see [R8]
                end
                default: begin
                    detect[i] = 1'b0;
                end
            endcase
            // Only a flag that was seen as 1 by an earlier read may be cleared by a 0.
            clear_sw[i] = wr_status && state_q.armed[i] && !bus_req.wdata[i]; // see [R9]
            // In level mode a held-low input keeps the request; the handler cannot drop it.
            clear_hw[i] = exc_ack[i]
                && ((mode != SENSE_LOW_LEVEL) || ext_request_input[i]); // see [R10]
        end
        new_event = detect & ~state_q.channel_pending_flag;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        state_d = state_q;

        // Input history for edge detection.
        state_d.prev_input = ext_request_input;

        // Configuration registers.
        if (wr_sense_high) begin
            state_d.sense_ctrl_high = bus_req.wdata; // see [R6]
        end
        if (wr_sense_low) begin
            state_d.sense_ctrl_low = bus_req.wdata; // see [R7]
        end
        if (wr_enables) begin
            state_d.enable_register = bus_req.wdata; // see [R5]
        end
        if (wr_event_mask) begin
            state_d.event_mask = bus_req.wdata;
        end

        // A detection in the same cycle as a clear wins, so no request is lost.
        state_d.channel_pending_flag = detect
            | (state_q.channel_pending_flag & ~(clear_sw | clear_hw)); // see [R8] see [R9]

        // A read of the flags arms the bits read as 1; any write to the flags disarms all.
        // Arming follows the flag, so a flag cleared and set again must be read once more.
        state_d.armed = state_q.armed;
        if (rd_status) begin
            state_d.armed = state_q.armed | state_q.channel_pending_flag; // see [R9]
        end
        if (wr_status) begin
            state_d.armed = 8'h00; // see [R9]
        end
        state_d.armed = state_d.armed & state_d.channel_pending_flag;

        // Sticky event bits, cleared by writing 1; a new event beats the clear.
        if (wr_event_status) begin
            state_d.event_status = new_event | (state_q.event_status & ~bus_req.wdata);
        end else begin
            state_d.event_status = new_event | state_q.event_status;
        end

        // Requests to the CPU track the next flag and enable values, so the output
        // register lines up with the flag register in the same cycle.
        state_d.requests = state_d.channel_pending_flag & state_d.enable_register; // see [R11] see [R5]
        state_d.irq = |(state_d.event_status & state_d.event_mask);

        // Read data stand only in the cycle after the read strobe.
        state_d.read_data = RST_READ_DATA;
        if (bus_req.rd) begin
            case (bus_req.addr)
                OFS_SENSE_CTRL_HIGH: begin
                    state_d.read_data = state_q.sense_ctrl_high;
                end
                OFS_SENSE_CTRL_LOW: begin
                    state_d.read_data = state_q.sense_ctrl_low;
                end
                OFS_LINE_ENABLES: begin
                    state_d.read_data = state_q.enable_register;
                end
                OFS_STATUS_FLAGS: begin
                    state_d.read_data = state_q.channel_pending_flag;
                end
                OFS_EVENT_STATUS: begin
                    state_d.read_data = state_q.event_status;
                end
                OFS_EVENT_MASK: begin
                    state_d.read_data = state_q.event_mask;
                end
                default: begin
                    state_d.read_data = UNMAPPED_READ;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q.sense_ctrl_high <= RST_SENSE_CTRL_HIGH; // see [R6]
            state_q.sense_ctrl_low <= RST_SENSE_CTRL_LOW; // see [R7]
            state_q.enable_register <= RST_LINE_ENABLES; // see [R5]
            state_q.channel_pending_flag <= RST_STATUS_FLAGS;
            state_q.armed <= RST_ARMED;
            // Idle-high history: a pin already low at release counts as a falling edge.
            state_q.prev_input <= RST_PREV_INPUT;
            state_q.event_status <= RST_EVENT_STATUS;
            state_q.event_mask <= RST_EVENT_MASK;
            state_q.read_data <= RST_READ_DATA;
            state_q.requests <= RST_REQUESTS;
            state_q.irq <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign rd_data = state_q.read_data;
    assign irq_request = state_q.requests;
    assign irq_out = state_q.irq;

endmodule // esirq_top

`default_nettype wire
